// file: core/swdt_pkg.sv
// Shared types and constants for the staged watchdog block.
// Assumes a single 200 MHz core clock and plain-port configuration.
package swdt_pkg;
  localparam int unsigned NUM_WDT       = 3;
  localparam int unsigned NUM_MAIN      = 2;
  localparam int unsigned NUM_STAGE     = 4;
  localparam int unsigned CNT_W         = 32;
  localparam int unsigned AON_IDX       = 2;
  localparam logic [31:0] UNLOCK_KEY    = 32'h5afe_c0de;
  localparam logic [31:0] BOOT_TIMEOUT  = 32'h0098_9680;
  localparam logic [31:0] RST_STAGE_DEF = 32'h0000_ffff;

  // Stage action encoding
  typedef enum logic [1:0] {
    SWDT_ACT_INT  = 2'h0,
    SWDT_ACT_CPU  = 2'h1,
    SWDT_ACT_CORE = 2'h2,
    SWDT_ACT_SYS  = 2'h3
  } swdt_act_t;

  typedef struct packed {
    logic      en;
    swdt_act_t act;
    logic [CNT_W-1:0] timeout;
  } swdt_stage_cfg_t;

  typedef struct packed {
    logic            wdt_en;
    swdt_stage_cfg_t [NUM_STAGE-1:0] stage;
  } swdt_cfg_t;

  typedef struct packed {
    logic intr;
    logic cpu_rst;
    logic core_rst;
    logic sys_rst;
  } swdt_evt_t;

  typedef enum logic [1:0] {
    SWDT_ST_IDLE = 2'h0,
    SWDT_ST_RUN  = 2'h1,
    SWDT_ST_HALT = 2'h3
  } swdt_state_t;
endpackage

// file: core/swdt_unit.sv
// One four-stage watchdog counter.
// Assumes configuration is already write-protected upstream.
`timescale 1ns/100ps
module swdt_unit
  import swdt_pkg::*;
#(
  parameter bit ALLOW_SYS = 1'b0
) (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               rstn,
  // Control
  input  wire swdt_pkg::swdt_cfg_t cfg,
  input  wire logic               feed,
  // Status and actions
  output swdt_pkg::swdt_evt_t     evt,
  output logic [1:0]              stage_idx,
  output logic [31:0]             count
);
  import swdt_pkg::*;

  typedef struct packed {
    swdt_state_t st;
    logic [1:0]  stg;
    logic [31:0] cnt;
    swdt_evt_t   evt;
  } swdt_unit_state_t;

  swdt_unit_state_t s_q, s_d;
  swdt_act_t        act_eff;

  always_comb begin
    s_d     = s_q;
    s_d.evt = '0;
    act_eff = cfg.stage[s_q.stg].act;
    // Main watchdogs have no system reset; demote to core reset
    if (!ALLOW_SYS && act_eff == SWDT_ACT_SYS) begin
      act_eff = SWDT_ACT_CORE;
    end
    if (!cfg.wdt_en) begin
      s_d.st  = SWDT_ST_IDLE;
      s_d.stg = 2'h0;
      s_d.cnt = '0;
    end else if (feed) begin
      s_d.st  = SWDT_ST_RUN;
      s_d.stg = 2'h0;
      s_d.cnt = '0;
    end else begin
      unique case (s_q.st)
        SWDT_ST_IDLE: begin
          s_d.st = SWDT_ST_RUN;
        end
        SWDT_ST_RUN: begin
          if (!cfg.stage[s_q.stg].en) begin
            s_d.cnt = '0;
            s_d.stg = s_q.stg + 2'h1;
            if (s_q.stg == 2'h3) begin
              s_d.st = SWDT_ST_HALT;
            end
          end else if (s_q.cnt + 32'h1 >= cfg.stage[s_q.stg].timeout) begin
            s_d.cnt = '0;
            s_d.stg = s_q.stg + 2'h1;
            unique case (act_eff)
              SWDT_ACT_INT:  s_d.evt.intr     = 1'b1;
              SWDT_ACT_CPU:  s_d.evt.cpu_rst  = 1'b1;
              SWDT_ACT_CORE: s_d.evt.core_rst = 1'b1;
              SWDT_ACT_SYS:  s_d.evt.sys_rst  = 1'b1;
            endcase
            if (s_q.stg == 2'h3) begin
              s_d.st = SWDT_ST_HALT;
            end
          end else begin
            s_d.cnt = s_q.cnt + 32'h1;
          end
        end
        SWDT_ST_HALT: begin
          s_d.st = SWDT_ST_HALT;
        end
        default: begin
          s_d.st = SWDT_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign evt       = s_q.evt;
  assign stage_idx = s_q.stg;
  assign count     = s_q.cnt;

  property p_feed_restart;
    @(posedge core_clk) disable iff (!rstn)
      (cfg.wdt_en && feed) |=> (stage_idx == 2'h0 && count == 32'h0);
  endproperty
  a_feed_restart: assert property (p_feed_restart) else $error("feed did not restart");

  property p_one_hot_evt;
    @(posedge core_clk) disable iff (!rstn)
      $onehot0({evt.intr, evt.cpu_rst, evt.core_rst, evt.sys_rst});
  endproperty
  a_one_hot_evt: assert property (p_one_hot_evt) else $error("several actions at once");

  property p_below_timeout;
    @(posedge core_clk) disable iff (!rstn)
      (s_q.st == SWDT_ST_RUN && cfg.stage[stage_idx].en && $stable(cfg))
        |-> (count < cfg.stage[stage_idx].timeout || count == 32'h0);
  endproperty
  a_below_timeout: assert property (p_below_timeout) else $error("count passed timeout");
endmodule

// file: core/swdt_top.sv
// Three staged watchdogs with write protection and flash boot guard.
// Assumes all control inputs come from logic on core_clk.
`timescale 1ns/100ps
module swdt_top
  import swdt_pkg::*;
#(
  // Boot guard length in core_clk cycles
  parameter logic [31:0] BOOT_LIMIT = BOOT_TIMEOUT
) (
  // Clock and reset
  input  wire logic                            core_clk,
  input  wire logic                            rstn,
  // Boot strap and completion
  input  wire logic                            flash_boot,
  input  wire logic                            boot_done,
  // Configuration write port
  input  wire logic [31:0]                     unlock_word,
  input  wire logic                            unlock_we,
  input  wire logic [swdt_pkg::NUM_WDT-1:0]    cfg_we,
  input  wire swdt_pkg::swdt_cfg_t             cfg_wdata,
  // Feed strobes
  input  wire logic [swdt_pkg::NUM_WDT-1:0]    feed,
  // Status
  output logic                                 unlocked,
  output logic [swdt_pkg::NUM_WDT-1:0][1:0]    stage_idx,
  output logic [swdt_pkg::NUM_WDT-1:0][31:0]   count,
  // Actions
  output logic [swdt_pkg::NUM_WDT-1:0]         wdt_intr,
  output logic                                 cpu_rst,
  output logic                                 core_rst,
  output logic                                 sys_rst
);
  import swdt_pkg::*;

  typedef struct packed {
    logic                      unlocked;
    swdt_cfg_t [NUM_WDT-1:0]   cfg;
    logic                      boot_arm;
    logic                      strap_seen;
    logic [31:0]               boot_cnt;
    logic [NUM_WDT-1:0]        intr;
    logic                      cpu_rst;
    logic                      core_rst;
    logic                      sys_rst;
  } swdt_top_state_t;

  swdt_top_state_t   s_q, s_d;
  swdt_evt_t [NUM_WDT-1:0] evt;

  // Boot default: all stages enabled, system reset (sys) or else core reset on final stage
  function automatic swdt_cfg_t boot_cfg(input logic sys);
    swdt_cfg_t c;
    c = '0;
    c.wdt_en = 1'b1;
    for (int i = 0; i < NUM_STAGE; i++) begin
      c.stage[i].en      = 1'b1;
      c.stage[i].timeout = RST_STAGE_DEF;
      c.stage[i].act     = SWDT_ACT_INT;
    end
    c.stage[NUM_STAGE-1].act = sys ? SWDT_ACT_SYS : SWDT_ACT_CORE;
    return c;
  endfunction

  always_comb begin
    s_d          = s_q;
    s_d.cpu_rst  = 1'b0;
    s_d.core_rst = 1'b0;
    s_d.sys_rst  = 1'b0;
    if (unlock_we) begin
      s_d.unlocked = (unlock_word == UNLOCK_KEY);
    end
    for (int i = 0; i < NUM_WDT; i++) begin
      if (cfg_we[i] && s_q.unlocked) begin
        s_d.cfg[i] = cfg_wdata;
      end
    end
    if (!s_q.strap_seen) begin
      s_d.strap_seen = 1'b1;
      if (flash_boot) begin
        s_d.boot_arm     = 1'b1;
        s_d.cfg[AON_IDX] = boot_cfg(1'b1);
        s_d.cfg[0]       = boot_cfg(1'b0);
      end
    end
    if (s_q.boot_arm) begin
      if (boot_done) begin
        s_d.boot_arm = 1'b0;
      end else if (s_q.boot_cnt + 32'h1 >= BOOT_LIMIT) begin
        s_d.boot_arm = 1'b0;
        s_d.sys_rst  = 1'b1;
      end else begin
        s_d.boot_cnt = s_q.boot_cnt + 32'h1;
      end
    end
    for (int i = 0; i < NUM_WDT; i++) begin
      s_d.intr[i] = evt[i].intr;
      if (evt[i].cpu_rst)  s_d.cpu_rst  = 1'b1;
      if (evt[i].core_rst) s_d.core_rst = 1'b1;
      if (evt[i].sys_rst)  s_d.sys_rst  = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  for (genvar g = 0; g < NUM_WDT; g++) begin : g_wdt
    swdt_unit #(
      .ALLOW_SYS (g == AON_IDX)
    ) u_unit (
      .core_clk  (core_clk),
      .rstn      (rstn),
      .cfg       (s_q.cfg[g]),
      .feed      (feed[g]),
      .evt       (evt[g]),
      .stage_idx (stage_idx[g]),
      .count     (count[g])
    );
  end

  assign unlocked = s_q.unlocked;
  assign wdt_intr = s_q.intr;
  assign cpu_rst  = s_q.cpu_rst;
  assign core_rst = s_q.core_rst;
  assign sys_rst  = s_q.sys_rst;

  property p_locked_write;
    @(posedge core_clk) disable iff (!rstn)
      (!s_q.unlocked && s_q.strap_seen) |=> $stable(s_q.cfg);
  endproperty
  a_locked_write: assert property (p_locked_write) else $error("locked config changed");

  property p_boot_enable;
    @(posedge core_clk) disable iff (!rstn)
      (!s_q.strap_seen && flash_boot) |=> (s_q.cfg[0].wdt_en && s_q.cfg[AON_IDX].wdt_en);
  endproperty
  a_boot_enable: assert property (p_boot_enable) else $error("boot enable missing");

  sequence s_guard_last;
    s_q.boot_arm && !boot_done && (s_q.boot_cnt + 32'h1 >= BOOT_LIMIT);
  endsequence

  sequence s_guard_fire;
    sys_rst && !s_q.boot_arm;
  endsequence

  property p_boot_timeout;
    @(posedge core_clk) disable iff (!rstn)
      s_guard_last |=> s_guard_fire;
  endproperty
  a_boot_timeout: assert property (p_boot_timeout) else $error("boot timeout lost");

  property p_main_no_sys;
    @(posedge core_clk) disable iff (!rstn)
      !(evt[0].sys_rst || evt[1].sys_rst);
  endproperty
  a_main_no_sys: assert property (p_main_no_sys) else $error("main raised system reset");

  property p_core_out;
    @(posedge core_clk) disable iff (!rstn)
      (evt[0].core_rst || evt[1].core_rst) |=> core_rst;
  endproperty
  a_core_out: assert property (p_core_out) else $error("core reset not driven");

  property p_sys_out;
    @(posedge core_clk) disable iff (!rstn)
      evt[AON_IDX].sys_rst |=> sys_rst;
  endproperty
  a_sys_out: assert property (p_sys_out) else $error("system reset not driven");

  property p_key_unlocks;
    @(posedge core_clk) disable iff (!rstn)
      (unlock_we && unlock_word == UNLOCK_KEY) |=> unlocked;
  endproperty
  a_key_unlocks: assert property (p_key_unlocks) else $error("key did not unlock");

  property p_bad_key_locks;
    @(posedge core_clk) disable iff (!rstn)
      (unlock_we && unlock_word != UNLOCK_KEY) |=> !unlocked;
  endproperty
  a_bad_key_locks: assert property (p_bad_key_locks) else $error("wrong key left unlocked");

  property p_cfg_lands;
    @(posedge core_clk) disable iff (!rstn)
      (s_q.unlocked && s_q.strap_seen && cfg_we[AON_IDX])
        |=> (s_q.cfg[AON_IDX] == $past(cfg_wdata));
  endproperty
  a_cfg_lands: assert property (p_cfg_lands) else $error("unlocked write lost");

  property p_no_strap_idle;
    @(posedge core_clk) disable iff (!rstn)
      (!s_q.strap_seen && !flash_boot) |=> !s_q.boot_arm;
  endproperty
  a_no_strap_idle: assert property (p_no_strap_idle) else $error("guard armed without strap");

  property p_done_disarms;
    @(posedge core_clk) disable iff (!rstn)
      (s_q.boot_arm && boot_done) |=> !s_q.boot_arm;
  endproperty
  a_done_disarms: assert property (p_done_disarms) else $error("guard still armed");
endmodule

// file: tb/tb.sv
// Self-checking bench for the three staged watchdogs.
// Assumes swdt_pkg and swdt_top are compiled first; checkers live in the design.
`timescale 1ns/100ps
module tb;
  import swdt_pkg::*;
  logic                    core_clk, rstn, flash_boot, boot_done, unlock_we;
  logic [31:0]             unlock_word;
  logic [NUM_WDT-1:0]      cfg_we, feed, wdt_intr;
  swdt_cfg_t               cfg_wdata;
  logic                    unlocked, cpu_rst, core_rst, sys_rst;
  logic [NUM_WDT-1:0][1:0] stage_idx;
  logic [NUM_WDT-1:0][31:0] count;
  int                      n_mismatch = 0;
  int                      n_checks = 0;
  int                      cyc;
  swdt_cfg_t               c;
  // Short boot guard so the bench reaches it
  localparam logic [31:0]  BOOT_LIM = 32'h0000_0064;

  swdt_top #(.BOOT_LIMIT(BOOT_LIM)) uut (.core_clk(core_clk), .rstn(rstn),
    .flash_boot(flash_boot), .boot_done(boot_done), .unlock_word(unlock_word),
    .unlock_we(unlock_we), .cfg_we(cfg_we), .cfg_wdata(cfg_wdata), .feed(feed),
    .unlocked(unlocked), .stage_idx(stage_idx), .count(count), .wdt_intr(wdt_intr),
    .cpu_rst(cpu_rst), .core_rst(core_rst), .sys_rst(sys_rst));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic do_reset(input logic fb);
    rstn = 1'b0;
    flash_boot = fb;
    boot_done = ~fb;
    tick(20);
    rstn = 1'b1;
    tick(2);
  endtask

  task automatic wr_key(input logic [31:0] k);
    unlock_word = k;
    unlock_we = 1'b1;
    tick(1);
    unlock_we = 1'b0;
    tick(1);
  endtask

  task automatic wr_cfg(input int i, input swdt_cfg_t v);
    cfg_wdata = v;
    cfg_we[i] = 1'b1;
    tick(1);
    cfg_we = '0;
    feed[i] = 1'b1;
    tick(1);
    feed = '0;
  endtask

  // Stage config: one enabled stage with action a and timeout t
  function automatic swdt_cfg_t one(input int s, input swdt_act_t a, input logic [31:0] t);
    swdt_cfg_t v;
    v = '0;
    v.wdt_en = 1'b1;
    v.stage[s] = '{en: 1'b1, act: a, timeout: t};
    return v;
  endfunction

  // Returns cycles until the chosen action pulses, -1 if none
  task automatic wait_evt(input int sel, input int i, input int mx, output int n);
    logic g;
    n = -1;
    for (int k = 1; k <= mx; k++) begin
      tick(1);
      g = (sel == 0) ? wdt_intr[i] : (sel == 1) ? cpu_rst : (sel == 2) ? core_rst : sys_rst;
      if (g === 1'b1) begin
        n = k;
        return;
      end
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #100000;
    n_mismatch++;
    stop_test();
  end

  initial begin
    {unlock_we, unlock_word, cfg_we, feed, cfg_wdata} = '0;
    // Flash boot starts the always-on and first main watchdog
    do_reset(1'b1);
    tick(10);
    chk("boot_run0", 1, count[0] > 0);
    chk("boot_run2", 1, count[2] > 0);
    chk("boot_idle1", 0, count[1]);
    // Boot never done: strap edge lies 11 edges back
    wait_evt(3, 0, 120, cyc);
    chk("boot_guard", BOOT_LIM - 32'h0000_000b, cyc);
    // Boot done in time: guard stays quiet
    do_reset(1'b1);
    boot_done = 1'b1;
    wait_evt(3, 0, 120, cyc);
    chk("boot_done_quiet", -1, cyc);
    $display("test boot done");
    do_reset(1'b0);
    chk("unlocked_rst", 0, unlocked);
    wr_cfg(1, one(0, SWDT_ACT_INT, 32'h0000_0064));
    tick(10);
    chk("locked_cnt", 0, count[1]);
    wr_key(UNLOCK_KEY);
    chk("unlocked", 1, unlocked);
    wr_key(32'h0000_0001);
    chk("relocked", 0, unlocked);
    wr_cfg(1, one(0, SWDT_ACT_INT, 32'h0000_0064));
    tick(10);
    chk("locked_cnt2", 0, count[1]);
    wr_key(UNLOCK_KEY);
    $display("test protect done");
    // Stage chain on main 0: stage 1 skipped, action 3 demoted
    c = one(0, SWDT_ACT_INT, 32'h0000_0014);
    c.stage[2] = '{en: 1'b1, act: SWDT_ACT_CPU, timeout: 32'h0000_001e};
    c.stage[3] = '{en: 1'b1, act: SWDT_ACT_SYS, timeout: 32'h0000_0028};
    wr_cfg(0, c);
    wait_evt(0, 0, 40, cyc);
    chk("st0_time", 1, cyc >= 18 && cyc <= 24);
    wait_evt(1, 0, 60, cyc);
    chk("st2_cpu", 1, cyc >= 28 && cyc <= 36);
    wait_evt(2, 0, 60, cyc);
    chk("st3_core", 1, cyc >= 38 && cyc <= 46);
    wait_evt(3, 0, 60, cyc);
    chk("no_sys", -1, cyc);
    $display("test chain done");
    // Every action code on main 1 and always-on
    for (int i = 1; i < 3; i++) begin
      for (int a = 0; a < 4; a++) begin
        wr_cfg(i, one(0, swdt_act_t'(a), 32'h0000_000a));
        wait_evt((i == 1 && a == 3) ? 2 : a, i, 20, cyc);
        chk("act_fire", 1, cyc > 0);
      end
    end
    $display("test actions done");
    // Feeding keeps stage 0 from expiring
    wr_cfg(0, one(0, SWDT_ACT_INT, 32'h0000_0014));
    for (int k = 0; k < 5; k++) begin
      wait_evt(0, 0, 10, cyc);
      chk("fed_no_intr", -1, cyc);
      feed[0] = 1'b1;
      tick(1);
      feed = '0;
      tick(1);
      chk("fed_stage", 0, stage_idx[0]);
      chk("fed_count", 1, count[0]);
    end
    wait_evt(0, 0, 30, cyc);
    chk("unfed_intr", 1, cyc > 0);
    // Feed while a later stage runs
    feed[0] = 1'b1;
    tick(1);
    feed = '0;
    tick(1);
    chk("late_feed_stage", 0, stage_idx[0]);
    chk("late_feed_count", 1, count[0]);
    $display("test feed done");
    stop_test();
  end
endmodule
